/* ptt_params.svh */
`ifndef PTT_PARAMS_SVH
`define PTT_PARAMS_SVH
// APB register byte offsets.
`define PTT_CTRL_OFF 8'h40
`define PTT_LDHI_OFF 8'h44
`define PTT_LDLO_OFF 8'h48
`define PTT_LDCMD_OFF 8'h4C
`define PTT_STAT_OFF 8'h50
// Reset values.
`define PTT_CTRL_RST 1'h0
`define PTT_SEG_RST 32'h0000_0000
`define PTT_WORD_RST 32'h0000_0000
// Segment register fields.
`define PTT_SEG_KS 30
`define PTT_SEG_KP 29
`define PTT_SEG_VIRTUAL_SEGMENT_ID 23:0
// Effective address fields, address bit 31 being the msb.
`define PTT_EA_SEG 31:28
`define PTT_EA_API 27:22
`define PTT_EA_XTR 21:17
`define PTT_EA_IDX 16:12
`define PTT_EA_PAGE 31:12
// Entry load words and load command fields.
`define PTT_HI_VIRTUAL_SEGMENT_ID 23:0
`define PTT_HI_API 29:24
`define PTT_LO_RPN 31:12
`define PTT_LO_C 7
`define PTT_LO_STORAGE_ATTRIBUTE_BITS 6:3
`define PTT_LO_PP 1:0
`define PTT_CMD_DSIDE 0
`define PTT_CMD_WAY 1
`define PTT_CMD_IDX 6:2
`define PTT_CMD_XTR 11:7
// Attribute bit positions within the four storage attribute bits.
`define PTT_STORAGE_ATTRIBUTE_BITS_W 3
`define PTT_STORAGE_ATTRIBUTE_BITS_I 2
// Status fields.
`define PTT_ST_VEC 15:0
`define PTT_ST_STALL 16
// Interrupt vector offsets.
`define PTT_VEC_IMISS 16'h1000
`define PTT_VEC_DLMISS 16'h1100
`define PTT_VEC_DSMISS 16'h1200
`define PTT_VEC_ALIGN 16'h0600
`define PTT_VEC_PROG 16'h0700
`define PTT_VEC_DPROT 16'h0300
`define PTT_VEC_IPROT 16'h0400
// Operation codes from the pipeline.
`define PTT_OP_INV 3'h1
`define PTT_OP_SYNC 3'h2
`define PTT_OP_INVALL 3'h3
`endif

/* ptt_pkg.sv */
package ptt_pkg;
  // One translation buffer entry: tag word then translation word.
  typedef struct packed {
    logic [23:0] virtual_segment_id;
    logic [5:0] abbreviated_page_index;
    logic [4:0] xtr;
    logic [19:0] real_page_number;
    logic chg;
    logic [3:0] storage_attribute_bits;
    logic [1:0] pp;
  } ptt_entry_s;
  // States of the invalidate synchronisation wait.
  typedef enum logic [0:0] {SY_IDLE, SY_WAIT} ptt_sync_e;
endpackage : ptt_pkg

/* ptt_sync3.sv */
`timescale 1ns/1ps
module ptt_sync3 (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Asynchronous level in, filtered level out.
  input wire logic async_in,
  output logic level_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // Three stages; the output follows once stages two and three agree.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      level_out <= 1'b1;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_out <= s3_r;
      end
    end
  end
endmodule : ptt_sync3

/* ptt_xlate.sv */
`timescale 1ns/1ps
`include "ptt_params.svh"
module ptt_xlate (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Lookup.
  input wire logic [31:0] lk_ea,
  input wire logic [23:0] lk_virtual_segment_id,
  output logic lk_hit,
  output ptt_pkg::ptt_entry_s lk_entry,
  // Entry load.
  input wire logic wr_en,
  input wire logic wr_way,
  input wire logic [4:0] wr_idx,
  input wire ptt_pkg::ptt_entry_s wr_entry,
  // Invalidation of both ways of one set.
  input wire logic inv_en,
  input wire logic [4:0] inv_idx
);
  logic [31:0] vld_r [0:1];
  ptt_pkg::ptt_entry_s mem_r [0:1][0:31];
  ptt_pkg::ptt_entry_s rd [0:1];
  logic [1:0] hit;

  // Each way keeps valid bits under reset and entry words without.
  for (genvar w = 0; w < 2; w++) begin : g_way
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        vld_r[w] <= 32'h0000_0000;
      end else begin
        if (wr_en && (wr_way == 1'(w))) begin
          vld_r[w][wr_idx] <= 1'b1;
        end
        // A same-set invalidate comes last, so it wins over a load there only.
        if (inv_en) begin
          vld_r[w][inv_idx] <= 1'b0;
        end
      end
    end

    always_ff @(posedge clk) begin
      if (wr_en && (wr_way == 1'(w))) begin
        mem_r[w][wr_idx] <= wr_entry;
      end
    end

    // The index picks one entry per way; valid, extra bits and tags compare.
    assign rd[w] = mem_r[w][lk_ea[`PTT_EA_IDX]];
    assign hit[w] = vld_r[w][lk_ea[`PTT_EA_IDX]] && (rd[w].virtual_segment_id == lk_virtual_segment_id) &&
                    (rd[w].abbreviated_page_index == lk_ea[`PTT_EA_API]) && (rd[w].xtr == lk_ea[`PTT_EA_XTR]);
  end

  // Either way may hit.
  assign lk_hit = |hit;
  assign lk_entry = hit[1] ? rd[1] : rd[0];
endmodule : ptt_xlate

/* ptt_top.sv */
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "ptt_params.svh"
// Contract
// - Both units look up in one cycle; one interrupt is reported at a time.
// - Instruction buffer miss interrupt waits until the pipeline is empty.
// - An entry holds a tag word and a translation word.
// - An entry also stores five extra page index bits.
// - Top four address bits select one of sixteen segment registers.
// - Five index bits select two entries; valid and tags are compared.
// - On a hit, protection and change bit are checked for interrupts.
// - A clean hit forwards real page number and attribute bits.
// - Entry invalidate clears both ways of the set in both buffers.
// - Invalidations are neither broadcast nor taken from other processors.
// - Sync operation stalls execution while the sync input is asserted.
// - The invalidate-all opcode raises an illegal instruction interrupt.
// - Zero-block on write-through or inhibited page raises alignment interrupt.
// - Instruction miss vectors to 0x1000, data load miss to 0x1100.
// - Store miss or store hit with change bit clear vectors to 0x1200.
// - Hardware never updates reference or change bits in memory.
module ptt_top (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Instruction side.
  input wire logic i_req,
  input wire logic [31:0] i_ea,
  input wire logic i_user,
  output logic i_xl_valid,
  output logic [19:0] i_rpn,
  output logic [3:0] i_storage_attribute_bits,
  output logic i_miss,
  // Data side.
  input wire logic d_req,
  input wire logic [31:0] d_ea,
  input wire logic d_store,
  input wire logic d_zero,
  input wire logic d_user,
  output logic d_xl_valid,
  output logic [19:0] d_rpn,
  output logic [3:0] d_storage_attribute_bits,
  output logic d_miss,
  // Operations from the pipeline.
  input wire logic op_valid,
  input wire logic [2:0] op_code,
  input wire logic [31:0] op_ea,
  output logic op_done,
  output logic exec_stall,
  // Pins and pipeline state.
  input wire logic inval_sync_n,
  input wire logic pipe_empty,
  // Interrupt report.
  output logic exc_valid,
  output logic [15:0] exc_vector
);
  logic [31:0] seg_r [0:15];
  logic xl_en_r;
  logic [31:0] ldhi_r;
  logic [31:0] ldlo_r;
  logic setup, acc, wr_acc, seg_sel, hi_zero, addr_ok, ld_go;
  logic [31:0] rd_val;
  logic [31:0] i_seg, d_seg;
  logic i_hit, d_hit, sync_lvl, sync_act, idle, op_inv, op_sync, p_ev;
  ptt_pkg::ptt_entry_s i_ent, d_ent, ld_entry;
  ptt_pkg::ptt_sync_e sy_state_r;
  logic [1:0] i_perm, d_perm;
  logic i_ev, i_fmiss, i_ok, d_fmiss, d_prot, d_align, d_chg, d_ev, d_ok;
  logic [15:0] i_vec_c, d_vec_c, i_cvec, i_pvec_r;
  logic [19:0] d_rpn_c;
  logic [4:0] inv_idx;
  logic i_pend_r, p_pend_r, i_cand, p_cand, i_ready, take_d, take_p, take_i;

  // Access rights {read, write} from protection bits and the selected key.
  function automatic logic [1:0] perm_of(input logic [1:0] pp, input logic key);
    perm_of = {~(key && (pp == 2'h0)), key ? (pp == 2'h2) : (pp != 2'h3)};
  endfunction : perm_of

  ////////////////////////////////////////////////////////////////////////////
  // APB decode and read data.
  assign setup = psel && !penable;
  assign acc = psel && penable && pready;
  assign wr_acc = acc && pwrite;
  assign hi_zero = (paddr[31:8] == 24'h00_0000);
  assign seg_sel = (paddr[31:6] == 26'h000_0000) && (paddr[1:0] == 2'h0);
  assign ld_go = wr_acc && hi_zero && (paddr[7:0] == `PTT_LDCMD_OFF);

  // Read multiplexer; unmapped addresses answer with an error.
  always_comb begin
    rd_val = 32'h0000_0000;
    addr_ok = 1'b0;
    if (seg_sel) begin
      rd_val = seg_r[paddr[5:2]];
      addr_ok = 1'b1;
    end else if (hi_zero) begin
      addr_ok = 1'b1;
      case (paddr[7:0])
        `PTT_CTRL_OFF: rd_val = {31'h0000_0000, xl_en_r};
        `PTT_LDHI_OFF: rd_val = ldhi_r;
        `PTT_LDLO_OFF: rd_val = ldlo_r;
        `PTT_LDCMD_OFF: rd_val = 32'h0000_0000;
        `PTT_STAT_OFF: rd_val = {15'h0000, exec_stall, exc_vector};
        default: addr_ok = 1'b0;
      endcase
    end
  end

  // One wait-free access phase: ready rises in the cycle after setup.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_val;
        pslverr <= !addr_ok;
      end
    end
  end

  // Sixteen segment registers, one per address slot.
  for (genvar g = 0; g < 16; g++) begin : g_seg
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        seg_r[g] <= `PTT_SEG_RST;
      end else if (wr_acc && seg_sel && (paddr[5:2] == 4'(g))) begin
        seg_r[g] <= pwdata;
      end
    end
  end

  // Control and entry load words.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      xl_en_r <= `PTT_CTRL_RST;
      ldhi_r <= `PTT_WORD_RST;
      ldlo_r <= `PTT_WORD_RST;
    end else if (wr_acc && hi_zero) begin
      if (paddr[7:0] == `PTT_CTRL_OFF) xl_en_r <= pwdata[0];
      if (paddr[7:0] == `PTT_LDHI_OFF) ldhi_r <= pwdata;
      if (paddr[7:0] == `PTT_LDLO_OFF) ldlo_r <= pwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Segment selection and the two buffers, both read in the same cycle.
  assign i_seg = seg_r[i_ea[`PTT_EA_SEG]];
  assign d_seg = seg_r[d_ea[`PTT_EA_SEG]];
  assign ld_entry = '{virtual_segment_id: ldhi_r[`PTT_HI_VIRTUAL_SEGMENT_ID], abbreviated_page_index: ldhi_r[`PTT_HI_API],
                      xtr: pwdata[`PTT_CMD_XTR], real_page_number: ldlo_r[`PTT_LO_RPN],
                      chg: ldlo_r[`PTT_LO_C], storage_attribute_bits: ldlo_r[`PTT_LO_STORAGE_ATTRIBUTE_BITS],
                      pp: ldlo_r[`PTT_LO_PP]};
  // Invalidation acts on the local buffers only, with no outgoing signal.
  assign inv_idx = op_ea[`PTT_EA_IDX];

  ptt_xlate u_ix (
    .clk(clk), .reset_n(reset_n), .lk_ea(i_ea), .lk_virtual_segment_id(i_seg[`PTT_SEG_VIRTUAL_SEGMENT_ID]),
    .lk_hit(i_hit), .lk_entry(i_ent), .wr_en(ld_go && !pwdata[`PTT_CMD_DSIDE]),
    .wr_way(pwdata[`PTT_CMD_WAY]), .wr_idx(pwdata[`PTT_CMD_IDX]), .wr_entry(ld_entry),
    .inv_en(op_inv), .inv_idx(inv_idx)
  );
  ptt_xlate u_dx (
    .clk(clk), .reset_n(reset_n), .lk_ea(d_ea), .lk_virtual_segment_id(d_seg[`PTT_SEG_VIRTUAL_SEGMENT_ID]),
    .lk_hit(d_hit), .lk_entry(d_ent), .wr_en(ld_go && pwdata[`PTT_CMD_DSIDE]),
    .wr_way(pwdata[`PTT_CMD_WAY]), .wr_idx(pwdata[`PTT_CMD_IDX]), .wr_entry(ld_entry),
    .inv_en(op_inv), .inv_idx(inv_idx)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Hit checks; with translation off the page passes through untranslated.
  assign i_perm = perm_of(i_ent.pp, i_user ? i_seg[`PTT_SEG_KP] : i_seg[`PTT_SEG_KS]);
  assign d_perm = perm_of(d_ent.pp, d_user ? d_seg[`PTT_SEG_KP] : d_seg[`PTT_SEG_KS]);
  assign i_fmiss = xl_en_r && i_req && !i_hit;
  assign i_ev = i_fmiss || (xl_en_r && i_req && i_hit && !i_perm[1]);
  assign i_ok = i_req && !i_ev;
  assign i_vec_c = i_fmiss ? `PTT_VEC_IMISS : `PTT_VEC_IPROT;
  assign d_fmiss = xl_en_r && d_req && !d_hit;
  assign d_prot = xl_en_r && d_req && d_hit && !(d_store ? d_perm[0] : d_perm[1]);
  assign d_align = xl_en_r && d_req && d_hit && !d_prot && d_zero &&
                   (d_ent.storage_attribute_bits[`PTT_STORAGE_ATTRIBUTE_BITS_W] || d_ent.storage_attribute_bits[`PTT_STORAGE_ATTRIBUTE_BITS_I]);
  // A clear change bit traps to software instead of being set here.
  assign d_chg = xl_en_r && d_req && d_hit && d_store && !d_prot && !d_align &&
                 !d_ent.chg;
  assign d_ev = d_fmiss || d_prot || d_align || d_chg;
  assign d_ok = d_req && !d_ev;
  assign d_rpn_c = xl_en_r ? d_ent.real_page_number : d_ea[`PTT_EA_PAGE];
  always_comb begin
    d_vec_c = `PTT_VEC_DSMISS;
    if (d_fmiss && !d_store) d_vec_c = `PTT_VEC_DLMISS;
    else if (d_prot) d_vec_c = `PTT_VEC_DPROT;
    else if (d_align) d_vec_c = `PTT_VEC_ALIGN;
  end

  // Translation results, registered one cycle after the request.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      i_xl_valid <= 1'b0;
      i_rpn <= 20'h0_0000;
      i_storage_attribute_bits <= 4'h0;
      i_miss <= 1'b0;
      d_xl_valid <= 1'b0;
      d_rpn <= 20'h0_0000;
      d_storage_attribute_bits <= 4'h0;
      d_miss <= 1'b0;
    end else begin
      i_xl_valid <= i_ok;
      i_rpn <= xl_en_r ? i_ent.real_page_number : i_ea[`PTT_EA_PAGE];
      i_storage_attribute_bits <= xl_en_r ? i_ent.storage_attribute_bits : 4'h0;
      i_miss <= i_fmiss;
      d_xl_valid <= d_ok;
      d_rpn <= d_rpn_c;
      d_storage_attribute_bits <= xl_en_r ? d_ent.storage_attribute_bits : 4'h0;
      d_miss <= d_fmiss;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operations and the invalidate synchronisation wait.
  ptt_sync3 u_sync (
    .clk(clk), .reset_n(reset_n), .async_in(inval_sync_n), .level_out(sync_lvl)
  );
  assign sync_act = !sync_lvl;
  assign idle = (sy_state_r == ptt_pkg::SY_IDLE);
  assign op_inv = op_valid && idle && (op_code == `PTT_OP_INV);
  assign op_sync = op_valid && idle && (op_code == `PTT_OP_SYNC);
  assign p_ev = op_valid && idle && (op_code == `PTT_OP_INVALL);

  // The wait ends once the synchronised input is seen negated.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sy_state_r <= ptt_pkg::SY_IDLE;
      exec_stall <= 1'b0;
      op_done <= 1'b0;
    end else begin
      case (sy_state_r)
        ptt_pkg::SY_IDLE: if (op_sync) sy_state_r <= ptt_pkg::SY_WAIT;
        ptt_pkg::SY_WAIT: if (!sync_act) sy_state_r <= ptt_pkg::SY_IDLE;
        default: sy_state_r <= ptt_pkg::SY_IDLE;
      endcase
      exec_stall <= sync_act && (op_sync || !idle);
      op_done <= (op_valid && idle && !op_sync) || (!idle && !sync_act);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt arbitration: data first, then program, then instruction.
  assign p_cand = p_ev || p_pend_r;
  assign i_cand = i_ev || i_pend_r;
  assign i_cvec = i_pend_r ? i_pvec_r : i_vec_c;
  assign i_ready = i_cand && ((i_cvec != `PTT_VEC_IMISS) || pipe_empty);
  assign take_d = d_ev;
  assign take_p = p_cand && !take_d;
  assign take_i = i_ready && !take_d && !p_cand;

  // Waiting events stay pending; a take clears its source, dropping a new event of that source.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      p_pend_r <= 1'b0;
      i_pend_r <= 1'b0;
      i_pvec_r <= 16'h0000;
      exc_valid <= 1'b0;
      exc_vector <= 16'h0000;
    end else begin
      p_pend_r <= p_cand && !take_p;
      i_pend_r <= i_cand && !take_i;
      i_pvec_r <= i_cvec;
      exc_valid <= take_d || take_p || take_i;
      if (take_d) exc_vector <= d_vec_c;
      else if (take_p) exc_vector <= `PTT_VEC_PROG;
      else if (take_i) exc_vector <= i_cvec;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the translation and interrupt behaviour.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_ONE_AT_A_TIME: assert property (
    (d_ev && i_ev && !i_pend_r) |=> exc_valid && (exc_vector == $past(d_vec_c)) && i_pend_r)
    else $error("Instruction event not held back behind a data event.");
  AST_IMISS_DEFER: assert property (
    (exc_valid && (exc_vector == `PTT_VEC_IMISS) && !$past(take_d)) |-> $past(pipe_empty))
    else $error("Instruction miss reported with a busy pipeline.");
  AST_NO_FORWARD_ON_MISS: assert property (
    (xl_en_r && d_req && !d_hit) |=> !d_xl_valid && d_miss && exc_valid)
    else $error("Data miss forwarded a translation.");
  AST_SEG_TAG: assert property (
    (xl_en_r && i_req && i_hit) |-> (i_ent.virtual_segment_id == seg_r[i_ea[`PTT_EA_SEG]][`PTT_SEG_VIRTUAL_SEGMENT_ID]))
    else $error("Instruction hit on another segment.");
  AST_CHANGE_TRAP: assert property (
    (d_chg) |=> exc_valid && (exc_vector == `PTT_VEC_DSMISS) && !d_xl_valid)
    else $error("Store to clean page was not trapped.");
  AST_FORWARD_RPN: assert property (
    d_xl_valid |-> $past(d_req) && (d_rpn == $past(d_rpn_c)))
    else $error("Forwarded page number does not match the entry.");
  AST_INV_CLEARS: assert property (
    (op_inv && !ld_go) |=> !(d_req && xl_en_r && (d_ea[`PTT_EA_IDX] == $past(inv_idx)) && d_hit))
    else $error("Invalidated set still hits.");
  AST_SYNC_STALL: assert property (
    (op_sync && sync_act) |=> exec_stall && !op_done)
    else $error("Sync did not stall while the input was asserted.");
  AST_SYNC_DONE: assert property (
    (!idle && !sync_act) |=> op_done && !exec_stall && idle)
    else $error("Sync did not complete after the input was negated.");
  AST_INVALL_PROG: assert property (
    p_ev |-> ##[1:8] (exc_valid && (exc_vector == `PTT_VEC_PROG)))
    else $error("Invalidate-all opcode raised no program interrupt.");
  AST_ALIGN_ZERO: assert property (
    d_align |=> exc_valid && (exc_vector == `PTT_VEC_ALIGN) && !d_xl_valid)
    else $error("Zero-block on special page not trapped.");
  AST_LOAD_MISS_VEC: assert property (
    (d_fmiss && !d_store) |=> (exc_vector == `PTT_VEC_DLMISS))
    else $error("Load miss took the wrong vector.");
  AST_STORE_MISS_VEC: assert property (
    (d_fmiss && d_store) |=> (exc_vector == `PTT_VEC_DSMISS))
    else $error("Store miss took the wrong vector.");

  COV_SYNC_WAIT: cover property (op_sync && sync_act ##1 exec_stall [*3] ##1 op_done);
  COV_IMISS_LATE: cover property (i_fmiss && !pipe_empty ##[1:20] take_i);
  COV_DATA_HIT: cover property (xl_en_r && d_req && d_hit ##1 d_xl_valid);
endmodule : ptt_top

/* ptt_pipe_model.sv */
`timescale 1ns/1ps
module ptt_pipe_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Requests from the bench.
  input wire logic busy,
  input wire logic sync_hold,
  // Pins toward the block.
  output logic pipe_empty,
  output logic inval_sync_n
);
  logic [1:0] drain_r;
  logic [1:0] drain_nxt;
  // The pipeline drains two cycles after the last instruction enters it.
  assign drain_nxt = busy ? 2'h2 : ((drain_r == 2'h0) ? 2'h0 : drain_r - 2'h1);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) drain_r <= 2'h0;
    else drain_r <= drain_nxt;
  end
  assign pipe_empty = (drain_r == 2'h0) && !busy;
  // A remote party keeps the sync pin asserted while its invalidation is in flight.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) inval_sync_n <= 1'b1;
    else inval_sync_n <= !sync_hold;
  end
endmodule : ptt_pipe_model

/* tb.sv */
`timescale 1ns/1ps
`include "ptt_params.svh"
module tb;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, err, busy, sync_hold;
  logic [31:0] paddr, pwdata, prdata, rd, i_ea, d_ea, op_ea;
  logic i_req, i_user, i_xl_valid, i_miss, d_req, d_store, d_zero, d_user, d_xl_valid, d_miss;
  logic [19:0] i_rpn, d_rpn;
  logic [3:0] i_storage_attribute_bits, d_storage_attribute_bits;
  logic op_valid, op_done, exec_stall, inval_sync_n, pipe_empty, exc_valid;
  logic [2:0] op_code;
  logic [15:0] exc_vector;
  int n_fail = 0;
  int n_tests = 0;
  localparam logic [31:0] EA_A = {4'h3, 6'h15, 5'h0A, 5'h07, 12'h000};
  localparam logic [31:0] EA_B = {4'h3, 6'h15, 5'h0A, 5'h08, 12'h000};
  // Page table in memory: entries 0 to 7 are the primary group, 8 to 15 the secondary.
  logic [31:0] pt_hi [0:15];
  logic [31:0] pt_lo [0:15];
  ////////////////////////////////////////////////////////////////////////////
  // The block and the pipeline model.
  ptt_top ptt_top_inst (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .i_req, .i_ea, .i_user, .i_xl_valid, .i_rpn, .i_storage_attribute_bits, .i_miss, .d_req,
    .d_ea, .d_store, .d_zero, .d_user, .d_xl_valid, .d_rpn, .d_storage_attribute_bits, .d_miss, .op_valid,
    .op_code, .op_ea, .op_done, .exec_stall, .inval_sync_n, .pipe_empty, .exc_valid,
    .exc_vector);
  ptt_pipe_model ptt_pipe_model_inst (.clk, .reset_n, .busy, .sync_hold, .pipe_empty,
    .inval_sync_n);
  // Free running clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Comparison, bus and stimulus helpers.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {24'h0, a};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Loads one entry through the load registers; protection allows read and write.
  task automatic ld(input logic ds, wy, input logic [31:0] ea, input logic [19:0] real_page_number,
      input logic c, input logic [3:0] storage_attribute_bits);
    apb(1'b1, `PTT_LDHI_OFF, {2'h0, ea[`PTT_EA_API], 20'h00010, ea[`PTT_EA_SEG]});
    apb(1'b1, `PTT_LDLO_OFF, {real_page_number, 4'h0, c, storage_attribute_bits, 3'h2});
    apb(1'b1, `PTT_LDCMD_OFF, {20'h0, ea[`PTT_EA_XTR], ea[`PTT_EA_IDX], wy, ds});
  endtask : ld
  task automatic look(input logic iq, dq, st, zr, input logic [31:0] ea);
    @(posedge clk);
    i_req <= iq;
    d_req <= dq;
    i_ea <= ea;
    d_ea <= ea;
    d_store <= st;
    d_zero <= zr;
    @(posedge clk);
    i_req <= 1'b0;
    d_req <= 1'b0;
    @(negedge clk);
  endtask : look
  task automatic op(input logic [2:0] code, input logic [31:0] ea);
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= code;
    op_ea <= ea;
    @(posedge clk);
    op_valid <= 1'b0;
  endtask : op
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_setup;
    for (int i = 0; i < 16; i++) apb(1'b1, 8'(i * 4), 32'h0000_0100 + i);
    apb(1'b0, 8'h14, 32'h0);
    chk("seg5", rd, 32'h0000_0105);
    apb(1'b0, 8'h80, 32'h0);
    chk("unmapped", {err, rd[30:0]}, 32'h8000_0000);
    // With translation off the page number passes through unchanged.
    look(1'b0, 1'b1, 1'b0, 1'b0, EA_A);
    chk("xl_off", {d_xl_valid, d_rpn}, 32'h135547);
    apb(1'b1, `PTT_CTRL_OFF, 32'h1);
  endtask : t_setup
  task automatic t_hit;
    ld(1'b1, 1'b1, EA_A, 20'hABCDE, 1'b1, 4'h3);
    ld(1'b0, 1'b0, EA_A, 20'h12345, 1'b1, 4'h3);
    look(1'b1, 1'b1, 1'b0, 1'b0, EA_A);
    chk("both", {i_xl_valid, d_xl_valid, exc_valid}, 32'h6);
    chk("d_rpn", {d_storage_attribute_bits, d_rpn}, 32'h3ABCDE);
    chk("i_rpn", {i_storage_attribute_bits, i_rpn}, 32'h312345);
    look(1'b0, 1'b1, 1'b0, 1'b0, EA_A ^ 32'h0002_0000);
    chk("xtr_miss", {d_miss, d_xl_valid}, 32'h2);
    chk("ld_vec", exc_vector, 32'h1100);
    look(1'b0, 1'b1, 1'b1, 1'b0, EA_A ^ 32'h1000_0000);
    chk("seg_miss", {d_miss, exc_vector}, 32'h11200);
  endtask : t_hit
  task automatic t_chg;
    ld(1'b1, 1'b0, EA_B, 20'h0BEEF, 1'b0, 4'h8);
    look(1'b0, 1'b1, 1'b0, 1'b0, EA_B);
    chk("ld_c0", {d_xl_valid, d_rpn}, 32'h10BEEF);
    look(1'b0, 1'b1, 1'b1, 1'b0, EA_B);
    chk("st_c0", {exc_valid, d_xl_valid, exc_vector}, 32'h21200);
    look(1'b0, 1'b1, 1'b1, 1'b1, EA_B);
    chk("zero_wt", {exc_valid, exc_vector}, 32'h10600);
  endtask : t_chg
  task automatic t_inv;
    @(posedge clk);
    busy <= 1'b1;
    op(`PTT_OP_INV, EA_A);
    look(1'b1, 1'b1, 1'b0, 1'b0, EA_A);
    chk("inv_miss", {i_miss, d_miss, exc_vector}, 32'h31100);
    repeat (4) begin
      @(negedge clk);
      chk("deferred", exc_valid, 32'h0);
    end
    @(posedge clk);
    busy <= 1'b0;
    repeat (12) if (exc_valid !== 1'b1) @(negedge clk);
    chk("i_vec", {exc_valid, exc_vector}, 32'h11000);
  endtask : t_inv
  task automatic t_invall;
    op(`PTT_OP_INVALL, 32'h0);
    repeat (8) if (exc_valid !== 1'b1) @(negedge clk);
    chk("invall", {exc_valid, exc_vector}, 32'h10700);
  endtask : t_invall
  task automatic t_sync;
    @(posedge clk);
    sync_hold <= 1'b1;
    repeat (6) @(posedge clk);
    op(`PTT_OP_SYNC, 32'h0);
    repeat (5) @(negedge clk);
    chk("stall", {exec_stall, op_done}, 32'h2);
    @(posedge clk);
    sync_hold <= 1'b0;
    repeat (12) if (op_done !== 1'b1) @(negedge clk);
    chk("resume", {exec_stall, op_done}, 32'h1);
  endtask : t_sync
  task automatic t_clear;
    for (int i = 0; i < 32; i++) op(`PTT_OP_INV, {15'h0, 5'(i), 12'h0});
    look(1'b0, 1'b1, 1'b0, 1'b0, EA_B);
    chk("cleared", {d_miss, d_xl_valid}, 32'h2);
  endtask : t_clear
  // User accesses to a no-access page on both sides: data reported first, then instruction.
  task automatic t_prot;
    apb(1'b1, 8'h0C, 32'h2000_0103);
    apb(1'b1, `PTT_LDHI_OFF, {2'h0, EA_A[`PTT_EA_API], 20'h00010, 4'h3});
    apb(1'b1, `PTT_LDLO_OFF, 32'h0005_5000);
    apb(1'b1, `PTT_LDCMD_OFF, {20'h0, EA_A[`PTT_EA_XTR], EA_A[`PTT_EA_IDX], 2'h1});
    apb(1'b1, `PTT_LDCMD_OFF, {20'h0, EA_A[`PTT_EA_XTR], EA_A[`PTT_EA_IDX], 2'h0});
    {i_user, d_user} <= 2'h3;
    look(1'b1, 1'b1, 1'b0, 1'b0, EA_A);
    chk("d_prot", {exc_valid, i_xl_valid, d_xl_valid, exc_vector}, 32'h40300);
    @(negedge clk);
    chk("i_prot", {exc_valid, exc_vector}, 32'h10400);
  endtask : t_prot
  // Software table search: primary group first, secondary only if it fails.
  task automatic t_walk(input logic [31:0] ea, input logic st, output logic flt);
    int hit;
    hit = -1;
    for (int k = 0; k < 16; k++) begin
      if (hit < 0 &&
          pt_hi[k] == {1'b1, 20'h00010, ea[`PTT_EA_SEG], 1'(k / 8), ea[`PTT_EA_API]}) begin
        hit = k;
      end
    end
    flt = (hit < 0);
    if (!flt) begin
      pt_lo[hit][8] = 1'b1;
      if (st && (pt_lo[hit][1:0] != 2'h3)) pt_lo[hit][7] = 1'b1;
      ld(1'b1, 1'b0, ea, pt_lo[hit][31:12], pt_lo[hit][7], pt_lo[hit][6:3]);
    end
  endtask : t_walk
  // A primary entry with the wrong hash bit must be skipped for the secondary one.
  task automatic t_search;
    logic flt;
    for (int k = 0; k < 16; k++) begin
      pt_hi[k] = 32'h0000_0000;
      pt_lo[k] = 32'h0000_0000;
    end
    pt_hi[2] = {1'b1, 24'h000103, 1'b1, EA_B[`PTT_EA_API]};
    pt_lo[2] = 32'h0AAA_A002;
    pt_hi[13] = {1'b1, 24'h000103, 1'b1, EA_B[`PTT_EA_API]};
    pt_lo[13] = 32'h0555_5002;
    t_walk(EA_B, 1'b1, flt);
    chk("walk", {flt, pt_lo[2][8:7], pt_lo[13][8:7]}, 32'h3);
    look(1'b0, 1'b1, 1'b1, 1'b0, EA_B);
    chk("walked", {d_xl_valid, d_rpn}, 32'h105555);
    t_walk(EA_A ^ 32'h0040_0000, 1'b0, flt);
    chk("fault", flt, 32'h1);
  endtask : t_search
  ////////////////////////////////////////////////////////////////////////////
  // Verdict, watchdog and main sequence.
  task automatic stop_test;
    if (n_fail == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  initial begin
    #100000;
    n_fail++;
    stop_test();
  end
  initial begin
    {reset_n, psel, penable, pwrite, i_req, i_user, d_req, d_store, d_zero, d_user} = '0;
    {op_valid, busy, sync_hold, err} = '0;
    {paddr, pwdata, i_ea, d_ea, op_ea, rd, op_code} = '0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    t_setup();
    t_hit();
    t_chg();
    t_inv();
    t_invall();
    t_sync();
    t_clear();
    t_prot();
    t_search();
    stop_test();
  end
endmodule : tb
